// [common/p1fs_pkg.sv]
/*
 port 1 function select package: mode and field encodings, pin indices.
 assumes nothing of its surroundings; constants only.
*/
package p1fs_pkg;
	localparam int P1FS_PINS = 6;
	localparam logic [3:0] P1FS_MD_NORMAL = 4'h0;
	localparam logic [3:0] P1FS_MD_PWM1 = 4'h2;
	localparam logic [3:0] P1FS_MD_PWM2 = 4'h3;
	localparam logic [1:0] P1FS_MD_PHASE_HI = 2'h1;
	localparam logic [1:0] P1FS_IO_CAPTURE_HI = 2'h2;
	localparam logic [1:0] P1FS_IO_OFF_LO = 2'h0;
	localparam logic [2:0] P1FS_PSC_111 = 3'h7;
	localparam logic [2:0] P1FS_PSC_101 = 3'h5;
	localparam logic [2:0] P1FS_PSC_100 = 3'h4;
	localparam logic [2:0] P1FS_RSEL_100 = 3'h4;
	localparam logic [1:0] P1FS_RSEL_01X = 2'h1;
	localparam logic [1:0] P1FS_SERIAL_GROUP_A = 2'h0;
	localparam logic [2:0] P1FS_CCLR_CH0_D = 3'h6;
	localparam logic [2:0] P1FS_CCLR_CH0_C = 3'h5;
	localparam logic [2:0] P1FS_CCLR_CH0_B = 3'h2;
	localparam logic [2:0] P1FS_CCLR_CH0_A = 3'h1;
	localparam logic [1:0] P1FS_CCLR_CH1_B = 2'h2;
	localparam logic [1:0] P1FS_CCLR_CH1_A = 2'h1;
	localparam int P1FS_IDX_10 = 0;
	localparam int P1FS_IDX_11 = 1;
	localparam int P1FS_IDX_12 = 2;
	localparam int P1FS_IDX_13 = 3;
	localparam int P1FS_IDX_14 = 4;
	localparam int P1FS_IDX_15 = 5;
	typedef enum logic [1:0] {
		P1FS_SRC_PORT,
		P1FS_SRC_PATTERN,
		P1FS_SRC_TIMER,
		P1FS_SRC_PERIPH
	} p1fs_src_e;
endpackage : p1fs_pkg

// [core/p1fs_pin_drive.sv]
/*
 one shared pin output resolver with fixed source priority.
 assumes the select terms are computed by the parent and are synchronous.
*/
`timescale 1ns/100ps
module p1fs_pin_drive
	import p1fs_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// claims and data, highest priority first
	input wire logic periph_claim,
	input wire logic periph_oe,
	input wire logic periph_data,
	input wire logic timer_claim,
	input wire logic timer_data,
	input wire logic direction,
	input wire logic pattern_enable,
	input wire logic pattern_data,
	input wire logic port_data,
	// pin drive
	output logic pin_out,
	output logic pin_oe,
	output p1fs_src_e source
);
	logic out_reg;
	logic out_next;
	logic oe_reg;
	logic oe_next;
	p1fs_src_e src_reg;
	p1fs_src_e src_next;

	always_comb begin
		out_next = port_data;
		oe_next = 1'b0;
		src_next = P1FS_SRC_PORT;
		if (periph_claim) begin
			out_next = periph_data;
			oe_next = periph_oe;
			src_next = P1FS_SRC_PERIPH;
		end else if (timer_claim) begin
			out_next = timer_data;
			oe_next = 1'b1;
			src_next = P1FS_SRC_TIMER;
		end else if (direction && pattern_enable) begin
			out_next = pattern_data;
			oe_next = 1'b1;
			src_next = P1FS_SRC_PATTERN;
		end else if (direction) begin
			oe_next = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			out_reg <= 1'b0;
			oe_reg <= 1'b0;
			src_reg <= P1FS_SRC_PORT;
		end else begin
			out_reg <= out_next;
			oe_reg <= oe_next;
			src_reg <= src_next;
		end
	end

	assign pin_out = out_reg;
	assign pin_oe = oe_reg;
	assign source = src_reg;

	chk_idle_input: assert property (@(posedge clock) disable iff (!reset_n)
		(!periph_claim && !timer_claim && !direction) |=> !pin_oe)
		else $error("unclaimed pin with direction 0 is driven");
	chk_periph_first: assert property (@(posedge clock) disable iff (!reset_n)
		periph_claim |=> (source == P1FS_SRC_PERIPH && pin_out == $past(periph_data)))
		else $error("peripheral claim lost priority");
	chk_pattern_drive: assert property (@(posedge clock) disable iff (!reset_n)
		(!periph_claim && !timer_claim && direction && pattern_enable)
		|=> (pin_oe && pin_out == $past(pattern_data)))
		else $error("pattern output not driven");
endmodule : p1fs_pin_drive

// [core/p1fs_port1_function_select.sv]
/*
 port 1 function select for pins 15 down to 10: picks per pin among port,
 pattern, timer, dma and serial functions and fans the pin inputs out.
 assumes all control bits are synchronous levels from the peripheral units.
*/
`timescale 1ns/100ps
module p1fs_port1_function_select
	import p1fs_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// shared pins 15..10 (index 0 is pin 10)
	input wire logic [5:0] pin_in,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe,
	// port registers
	input wire logic [5:0] pin_direction,
	input wire logic [5:0] port_data,
	// pattern generator
	input wire logic [5:0] pattern_output,
	input wire logic [5:0] pattern_output_enable,
	// timer channel 0
	input wire logic [3:0] timer0_mode_field,
	input wire logic [3:0] timer0_io_ctrl_a,
	input wire logic [3:0] timer0_io_ctrl_b,
	input wire logic [3:0] timer0_io_ctrl_c,
	input wire logic [3:0] timer0_io_ctrl_d,
	input wire logic [2:0] timer0_counter_clear_select,
	input wire logic buffer_mode_a,
	input wire logic buffer_mode_b,
	input wire logic [3:0] timer0_compare_out,
	// timer channel 1
	input wire logic [3:0] timer1_mode_field,
	input wire logic [3:0] timer1_io_ctrl_a,
	input wire logic [3:0] timer1_io_ctrl_b,
	input wire logic [1:0] timer1_counter_clear_select,
	input wire logic [1:0] timer1_compare_out,
	// timer prescale selects, channels 0..5, and phase counting
	input wire logic [17:0] timer_prescale_select,
	input wire logic phase_count_ch1_ch5,
	input wire logic phase_count_ch2_ch4,
	// dma controller
	input wire logic dma_compat_mode,
	input wire logic ext_single_addr_enable_0,
	input wire logic ext_single_addr_enable_1,
	input wire logic single_addr_enable_ch0,
	input wire logic single_addr_enable_ch1,
	input wire logic [2:0] dma_end_route_select_hi,
	input wire logic [2:0] dma_end_route_select_lo,
	input wire logic transfer_end_enable_ch0,
	input wire logic transfer_end_enable_ch1,
	input wire logic ext_end_route_bit0,
	input wire logic ext_end_route_bit1,
	input wire logic ext_transfer_end_enable_0,
	input wire logic ext_transfer_end_enable_1,
	input wire logic ext_transfer_end_enable_4,
	input wire logic ext_transfer_end_enable_5,
	input wire logic [5:0] dma_acknowledge,
	input wire logic [5:0] transfer_end,
	// sync serial unit
	input wire logic [1:0] serial_pin_group_select,
	input wire logic serial_in_used,
	input wire logic serial_in_drive,
	input wire logic serial_out_used,
	input wire logic serial_out_drive,
	input wire logic serial_in_data,
	input wire logic serial_out_data,
	// peripheral inputs from the pins
	output logic timer0_capcomp_a,
	output logic timer0_capcomp_b,
	output logic timer0_capcomp_c,
	output logic timer0_capcomp_d,
	output logic timer1_capcomp_a,
	output logic timer1_capcomp_b,
	output logic timer_ext_clock_a,
	output logic timer_ext_clock_b,
	output logic timer_ext_clock_c,
	output logic [5:0] dma_request,
	output logic sync_serial_in_a,
	output logic sync_serial_out_a,
	// which source drives each pin
	output p1fs_src_e [5:0] pin_source
);
	logic [5:0] periph_claim;
	logic [5:0] periph_oe;
	logic [5:0] periph_data;
	logic [5:0] timer_claim;
	logic [5:0] timer_data;
	logic [5:0] cap_sel;
	logic clk_a_sel;
	logic clk_b_sel;
	logic clk_c_sel;
	logic serial_a;
	logic ack15_1;
	logic ack15_3;
	logic ack14_0;
	logic ack14_1;
	logic [1:0] end13;
	logic [1:0] end12;
	logic [5:0] in_next;
	logic [5:0] in_reg;
	logic [8:0] fan_next;
	logic [8:0] fan_reg;
	logic [5:0] req_next;
	logic [5:0] req_reg;

	// output compare when io ctrl is 0001..0011 or 0101..0111
	function automatic logic compare_io(input logic [3:0] io);
		compare_io = !io[3] && (io[1:0] != P1FS_IO_OFF_LO);
	endfunction : compare_io

	function automatic logic capture_io(input logic [3:0] io);
		capture_io = (io[3:2] == P1FS_IO_CAPTURE_HI);
	endfunction : capture_io

	// timer channel 0 and 1 claims; pwm mode 2 cleared by that pin's own cclr
	always_comb begin
		timer_claim = '0;
		timer_data = '0;
		cap_sel = '0;
		if (timer0_mode_field == P1FS_MD_NORMAL) begin
			timer_claim[P1FS_IDX_10] = compare_io(timer0_io_ctrl_a);
			timer_claim[P1FS_IDX_11] = compare_io(timer0_io_ctrl_b);
			timer_claim[P1FS_IDX_12] = compare_io(timer0_io_ctrl_c);
			timer_claim[P1FS_IDX_13] = compare_io(timer0_io_ctrl_d);
			cap_sel[P1FS_IDX_10] = capture_io(timer0_io_ctrl_a);
			cap_sel[P1FS_IDX_11] = capture_io(timer0_io_ctrl_b);
			cap_sel[P1FS_IDX_12] = capture_io(timer0_io_ctrl_c);
			cap_sel[P1FS_IDX_13] = capture_io(timer0_io_ctrl_d);
		end else if (timer0_mode_field == P1FS_MD_PWM1) begin
			// pwm mode 1 uses the a/c pin; b/d outputs are disabled
			timer_claim[P1FS_IDX_10] = timer0_io_ctrl_a[1:0] != P1FS_IO_OFF_LO;
			timer_claim[P1FS_IDX_12] = (timer0_io_ctrl_c[1:0] != P1FS_IO_OFF_LO)
				&& !buffer_mode_a && !buffer_mode_b;
		end else if (timer0_mode_field == P1FS_MD_PWM2) begin
			// an io field of xx00 leaves the pin to the port even in pwm mode 2
			timer_claim[P1FS_IDX_10] = timer0_counter_clear_select != P1FS_CCLR_CH0_A
				&& timer0_io_ctrl_a[1:0] != P1FS_IO_OFF_LO;
			timer_claim[P1FS_IDX_11] = timer0_counter_clear_select != P1FS_CCLR_CH0_B
				&& timer0_io_ctrl_b[1:0] != P1FS_IO_OFF_LO;
			timer_claim[P1FS_IDX_12] = timer0_counter_clear_select != P1FS_CCLR_CH0_C
				&& timer0_io_ctrl_c[1:0] != P1FS_IO_OFF_LO;
			timer_claim[P1FS_IDX_13] = timer0_counter_clear_select != P1FS_CCLR_CH0_D
				&& timer0_io_ctrl_d[1:0] != P1FS_IO_OFF_LO;
		end
		if (timer1_mode_field == P1FS_MD_NORMAL || timer1_mode_field[3:2] == P1FS_MD_PHASE_HI) begin
			timer_claim[P1FS_IDX_14] = compare_io(timer1_io_ctrl_a);
			timer_claim[P1FS_IDX_15] = compare_io(timer1_io_ctrl_b);
			cap_sel[P1FS_IDX_14] = capture_io(timer1_io_ctrl_a);
			cap_sel[P1FS_IDX_15] = capture_io(timer1_io_ctrl_b);
		end else if (timer1_mode_field == P1FS_MD_PWM1) begin
			timer_claim[P1FS_IDX_14] = timer1_io_ctrl_a[1:0] != P1FS_IO_OFF_LO;
		end else if (timer1_mode_field == P1FS_MD_PWM2) begin
			timer_claim[P1FS_IDX_14] = timer1_counter_clear_select != P1FS_CCLR_CH1_A
				&& timer1_io_ctrl_a[1:0] != P1FS_IO_OFF_LO;
			timer_claim[P1FS_IDX_15] = timer1_counter_clear_select != P1FS_CCLR_CH1_B
				&& timer1_io_ctrl_b[1:0] != P1FS_IO_OFF_LO;
		end
		timer_data = {timer1_compare_out[1], timer1_compare_out[0], timer0_compare_out[3],
			timer0_compare_out[2], timer0_compare_out[1], timer0_compare_out[0]};
	end

	// external clock selects, three prescale bits per channel
	always_comb begin
		clk_a_sel = phase_count_ch1_ch5;
		clk_b_sel = phase_count_ch1_ch5;
		for (int ch = 0; ch < 6; ch++) begin
			if (timer_prescale_select[3 * ch +: 3] == P1FS_PSC_100) begin
				clk_a_sel = 1'b1;
			end
			if (ch < 3 && timer_prescale_select[3 * ch +: 3] == P1FS_PSC_101) begin
				clk_b_sel = 1'b1;
			end
		end
		clk_c_sel = phase_count_ch2_ch4
			|| timer_prescale_select[2:0] == P1FS_PSC_111
			|| timer_prescale_select[8:6] == P1FS_PSC_111
			|| timer_prescale_select[14:12] == P1FS_PSC_101
			|| timer_prescale_select[17:15] == P1FS_PSC_101;
	end

	// dma acknowledge, transfer end and serial claims
	always_comb begin
		serial_a = serial_pin_group_select == P1FS_SERIAL_GROUP_A;
		ack15_1 = !dma_compat_mode && ext_single_addr_enable_1;
		ack15_3 = dma_compat_mode && single_addr_enable_ch1;
		ack14_0 = !dma_compat_mode && ext_single_addr_enable_0;
		ack14_1 = dma_compat_mode && single_addr_enable_ch0;
		end13 = '0;
		end12 = '0;
		if (dma_compat_mode) begin
			if (dma_end_route_select_hi == P1FS_RSEL_100 && transfer_end_enable_ch1) begin
				end13 = 2'h1;
			end else if (dma_end_route_select_hi[2:1] == P1FS_RSEL_01X
				&& transfer_end_enable_ch1) begin
				end13 = 2'h2;
			end
			if (dma_end_route_select_lo == P1FS_RSEL_100 && transfer_end_enable_ch0) begin
				end12 = 2'h1;
			end else if (dma_end_route_select_lo[2:1] == P1FS_RSEL_01X
				&& transfer_end_enable_ch0) begin
				end12 = 2'h2;
			end
		end else begin
			if (ext_end_route_bit1 && ext_transfer_end_enable_5) begin
				end13 = 2'h1;
			end else if (!ext_end_route_bit1 && ext_transfer_end_enable_1) begin
				end13 = 2'h3;
			end
			if (ext_end_route_bit0 && ext_transfer_end_enable_4) begin
				end12 = 2'h1;
			end else if (!ext_end_route_bit0 && ext_transfer_end_enable_0) begin
				end12 = 2'h3;
			end
		end
		periph_claim = '0;
		periph_oe = '0;
		periph_data = '0;
		// end codes: 1 upper end signal, 2 middle, 3 lower
		periph_claim[P1FS_IDX_13] = end13 != 2'h0;
		periph_oe[P1FS_IDX_13] = end13 != 2'h0;
		periph_data[P1FS_IDX_13] = (end13 == 2'h1) ? transfer_end[5]
			: (end13 == 2'h2) ? transfer_end[3] : transfer_end[1];
		periph_claim[P1FS_IDX_12] = end12 != 2'h0;
		periph_oe[P1FS_IDX_12] = end12 != 2'h0;
		periph_data[P1FS_IDX_12] = (end12 == 2'h1) ? transfer_end[4]
			: (end12 == 2'h2) ? transfer_end[1] : transfer_end[0];
		// serial first: software keeps dma off while the serial unit owns the pin
		if (serial_a && serial_in_used) begin
			periph_claim[P1FS_IDX_15] = 1'b1;
			periph_oe[P1FS_IDX_15] = serial_in_drive;
			periph_data[P1FS_IDX_15] = serial_in_data;
		end else if (ack15_1 || ack15_3) begin
			periph_claim[P1FS_IDX_15] = 1'b1;
			periph_oe[P1FS_IDX_15] = 1'b1;
			periph_data[P1FS_IDX_15] = ack15_1 ? dma_acknowledge[1] : dma_acknowledge[3];
		end
		if (serial_a && serial_out_used) begin
			periph_claim[P1FS_IDX_14] = 1'b1;
			periph_oe[P1FS_IDX_14] = serial_out_drive;
			periph_data[P1FS_IDX_14] = serial_out_data;
		end else if (ack14_0 || ack14_1) begin
			periph_claim[P1FS_IDX_14] = 1'b1;
			periph_oe[P1FS_IDX_14] = 1'b1;
			periph_data[P1FS_IDX_14] = ack14_0 ? dma_acknowledge[0] : dma_acknowledge[1];
		end
	end

	// input fan-out: pin samples are registered to keep peripheral inputs glitch free
	always_comb begin
		in_next = pin_in & cap_sel;
		fan_next = {serial_a & pin_in[P1FS_IDX_14], serial_a & pin_in[P1FS_IDX_15],
			clk_c_sel & pin_in[P1FS_IDX_15], clk_b_sel & pin_in[P1FS_IDX_13],
			clk_a_sel & pin_in[P1FS_IDX_12], 4'h0};
		req_next = '0;
		req_next[0] = !dma_compat_mode & pin_in[P1FS_IDX_10];
		req_next[1] = dma_compat_mode ? pin_in[P1FS_IDX_10] : pin_in[P1FS_IDX_11];
		req_next[3] = dma_compat_mode & pin_in[P1FS_IDX_11];
		req_next[4] = pin_in[P1FS_IDX_10];
		req_next[5] = pin_in[P1FS_IDX_11];
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_reg <= '0;
			fan_reg <= '0;
			req_reg <= '0;
		end else begin
			in_reg <= in_next;
			fan_reg <= fan_next;
			req_reg <= req_next;
		end
	end

	assign timer0_capcomp_a = in_reg[P1FS_IDX_10];
	assign timer0_capcomp_b = in_reg[P1FS_IDX_11];
	assign timer0_capcomp_c = in_reg[P1FS_IDX_12];
	assign timer0_capcomp_d = in_reg[P1FS_IDX_13];
	assign timer1_capcomp_a = in_reg[P1FS_IDX_14];
	assign timer1_capcomp_b = in_reg[P1FS_IDX_15];
	assign timer_ext_clock_a = fan_reg[4];
	assign timer_ext_clock_b = fan_reg[5];
	assign timer_ext_clock_c = fan_reg[6];
	assign sync_serial_in_a = fan_reg[7];
	assign sync_serial_out_a = fan_reg[8];
	assign dma_request = req_reg;

	for (genvar i = 0; i < P1FS_PINS; i++) begin : g_pin
		p1fs_pin_drive u_drive (
			.clock(clock),
			.reset_n(reset_n),
			.periph_claim(periph_claim[i]),
			.periph_oe(periph_oe[i]),
			.periph_data(periph_data[i]),
			.timer_claim(timer_claim[i]),
			.timer_data(timer_data[i]),
			.direction(pin_direction[i]),
			.pattern_enable(pattern_output_enable[i]),
			.pattern_data(pattern_output[i]),
			.port_data(port_data[i]),
			.pin_out(pin_out[i]),
			.pin_oe(pin_oe[i]),
			.source(pin_source[i])
		);
	end

	chk_cap_b1_route: assert property (@(posedge clock) disable iff (!reset_n)
		(timer1_mode_field == P1FS_MD_NORMAL && timer1_io_ctrl_b[3:2] == 2'h2)
		|=> timer1_capcomp_b == $past(pin_in[5]))
		else $error("pin15 not routed to timer1 capture b");
	chk_cap_d0_route: assert property (@(posedge clock) disable iff (!reset_n)
		(timer0_mode_field != P1FS_MD_NORMAL) |=> !timer0_capcomp_d)
		else $error("pin13 captured outside normal mode");
	chk_clk_a_route: assert property (@(posedge clock) disable iff (!reset_n)
		(timer_prescale_select[11:9] == 3'h4) |=> timer_ext_clock_a == $past(pin_in[2]))
		else $error("pin12 not routed to external clock a");
	chk_req_compat: assert property (@(posedge clock) disable iff (!reset_n)
		dma_compat_mode |=> (dma_request[3] == $past(pin_in[1]) && !dma_request[0]))
		else $error("dma request routing wrong in compat mode");
	chk_req_always: assert property (@(posedge clock) disable iff (!reset_n)
		1'b1 |=> dma_request[4] == $past(pin_in[0]))
		else $error("dma request 4 not following pin10");
	chk_ack_pin15: assert property (@(posedge clock) disable iff (!reset_n)
		(serial_pin_group_select != 2'h0 && dma_compat_mode && single_addr_enable_ch1)
		|=> (pin_oe[5] && pin_out[5] == $past(dma_acknowledge[3])))
		else $error("pin15 does not carry acknowledge 3");
	chk_buffer_mute: assert property (@(posedge clock) disable iff (!reset_n)
		(timer0_mode_field == P1FS_MD_PWM1 && (buffer_mode_a || buffer_mode_b) && end12 == 2'h0)
		|=> pin_source[2] != P1FS_SRC_TIMER)
		else $error("pwm1 output on pin12 under buffer mode");
	chk_end_pin13: assert property (@(posedge clock) disable iff (!reset_n)
		(!dma_compat_mode && ext_end_route_bit1 && ext_transfer_end_enable_5)
		|=> (pin_oe[3] && pin_out[3] == $past(transfer_end[5])))
		else $error("pin13 does not carry end signal 5");
endmodule : p1fs_port1_function_select

// [dv/p1fs_board_model.sv]
/*
 board side of port 1: external circuitry on the six shared pins.
 assumes the bench commands which pins the board drives; pull-ups elsewhere.
*/
`timescale 1ns/100ps
module p1fs_board_model (
	// device side
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	// bench commands
	input wire logic [5:0] drive_val,
	input wire logic [5:0] drive_en,
	// pin level seen by the device
	output logic [5:0] pin_in
);
	// the device wins a contention; an undriven pin floats up to the pull-up level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_en & drive_val) | (~pin_oe & ~drive_en);
endmodule : p1fs_board_model

// [dv/p1fs_port1_function_select_tb_top.sv]
/*
 self-checking bench for the port 1 function selector.
 assumes outputs register one cycle after inputs and the board model on the pins.
*/
`timescale 1ns/100ps
module p1fs_port1_function_select_tb_top;
	import p1fs_pkg::*;
	logic clock, reset_n;
	logic [5:0] pin_direction, port_data, pattern_output, pattern_output_enable;
	logic [5:0] dma_acknowledge, transfer_end, drive_val, drive_en, pin_in, pin_out, pin_oe;
	logic [5:0] dma_request;
	logic [3:0] timer0_mode_field, timer0_io_ctrl_a, timer0_io_ctrl_b, timer0_io_ctrl_c;
	logic [3:0] timer0_io_ctrl_d, timer0_compare_out, timer1_mode_field, timer1_io_ctrl_a;
	logic [3:0] timer1_io_ctrl_b;
	logic [2:0] timer0_counter_clear_select, dma_end_route_select_hi, dma_end_route_select_lo;
	logic [1:0] timer1_counter_clear_select, timer1_compare_out, serial_pin_group_select;
	logic [17:0] timer_prescale_select;
	logic buffer_mode_a, buffer_mode_b, phase_count_ch1_ch5, phase_count_ch2_ch4;
	logic dma_compat_mode, ext_single_addr_enable_0, ext_single_addr_enable_1;
	logic single_addr_enable_ch0, single_addr_enable_ch1, transfer_end_enable_ch0;
	logic transfer_end_enable_ch1, ext_end_route_bit0, ext_end_route_bit1;
	logic ext_transfer_end_enable_0, ext_transfer_end_enable_1, ext_transfer_end_enable_4;
	logic ext_transfer_end_enable_5, serial_in_used, serial_in_drive, serial_out_used;
	logic serial_out_drive, serial_in_data, serial_out_data;
	logic timer0_capcomp_a, timer0_capcomp_b, timer0_capcomp_c, timer0_capcomp_d;
	logic timer1_capcomp_a, timer1_capcomp_b, timer_ext_clock_a, timer_ext_clock_b;
	logic timer_ext_clock_c, sync_serial_in_a, sync_serial_out_a;
	p1fs_src_e [5:0] pin_source;
	int mismatches = 0;
	int checks_done = 0;

	p1fs_port1_function_select uut (.*);
	p1fs_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .drive_val(drive_val),
		.drive_en(drive_en), .pin_in(pin_in));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task summarize;
		if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize

	task chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask : chk

	// inputs move 5 ns after the edge, outputs are read 5 ns after the next one
	task tick;
		@(posedge clock);
		#5;
	endtask : tick

	task clear;
		{pin_direction, port_data, pattern_output, pattern_output_enable, dma_acknowledge,
			transfer_end, drive_val, drive_en, timer0_mode_field, timer0_io_ctrl_a,
			timer0_io_ctrl_b, timer0_io_ctrl_c, timer0_io_ctrl_d, timer0_compare_out,
			timer1_mode_field, timer1_io_ctrl_a, timer1_io_ctrl_b, timer0_counter_clear_select,
			dma_end_route_select_hi, dma_end_route_select_lo, timer1_counter_clear_select,
			timer1_compare_out, serial_pin_group_select, timer_prescale_select, buffer_mode_a,
			buffer_mode_b, phase_count_ch1_ch5, phase_count_ch2_ch4, dma_compat_mode,
			ext_single_addr_enable_0, ext_single_addr_enable_1, single_addr_enable_ch0,
			single_addr_enable_ch1, transfer_end_enable_ch0, transfer_end_enable_ch1,
			ext_end_route_bit0, ext_end_route_bit1, ext_transfer_end_enable_0,
			ext_transfer_end_enable_1, ext_transfer_end_enable_4, ext_transfer_end_enable_5,
			serial_in_used, serial_in_drive, serial_out_used, serial_out_drive, serial_in_data,
			serial_out_data} = '0;
		// serial group left non-zero so no test mixes serial with timer or dma use
		serial_pin_group_select = 2'h3;
	endtask : clear

	task t_port;
		clear();
		tick();
		chk(pin_oe, 6'h00);
		pin_direction = 6'h3f;
		port_data = 6'h2a;
		pattern_output = 6'h15;
		pattern_output_enable = 6'h0f;
		tick();
		chk(pin_oe, 6'h3f);
		chk(pin_out, 6'h25);
		chk(pin_source, {P1FS_SRC_PORT, P1FS_SRC_PORT, {4{P1FS_SRC_PATTERN}}});
		timer0_io_ctrl_a = 4'h1;
		tick();
		chk({pin_source[0], pin_out[0]}, {P1FS_SRC_TIMER, 1'b0});
		timer0_io_ctrl_a = 4'h0;
		timer0_mode_field = P1FS_MD_PWM1;
		timer0_io_ctrl_b = 4'h1;
		timer0_io_ctrl_c = 4'h1;
		timer0_compare_out = 4'hf;
		buffer_mode_a = 1'b1;
		tick();
		chk(pin_source[2], P1FS_SRC_PATTERN);
		chk(pin_source[1], P1FS_SRC_PATTERN);
		buffer_mode_a = 1'b0;
		tick();
		chk({pin_source[2], pin_out[2]}, {P1FS_SRC_TIMER, 1'b1});
		timer1_mode_field = P1FS_MD_PWM1;
		{timer1_io_ctrl_a, timer1_io_ctrl_b} = 8'h11;
		timer0_mode_field = P1FS_MD_PWM2;
		timer0_io_ctrl_a = 4'h1;
		timer0_counter_clear_select = P1FS_CCLR_CH0_A;
		tick();
		chk(pin_source, {P1FS_SRC_PORT, P1FS_SRC_TIMER, P1FS_SRC_PATTERN, {2{P1FS_SRC_TIMER}},
			P1FS_SRC_PATTERN});
	endtask : t_port

	task t_capture;
		clear();
		// let the port outputs of the last scenario release the pins first
		tick();
		drive_en = 6'h3f;
		drive_val = 6'h3f;
		{timer0_io_ctrl_a, timer0_io_ctrl_b, timer0_io_ctrl_c, timer0_io_ctrl_d} = 16'h8888;
		{timer1_io_ctrl_a, timer1_io_ctrl_b} = 8'h88;
		timer1_mode_field = 4'h4;
		tick();
		chk({timer1_capcomp_b, timer1_capcomp_a, timer0_capcomp_d, timer0_capcomp_c,
			timer0_capcomp_b, timer0_capcomp_a}, 6'h3f);
		drive_val = 6'h15;
		tick();
		chk({timer1_capcomp_b, timer1_capcomp_a, timer0_capcomp_d, timer0_capcomp_c,
			timer0_capcomp_b, timer0_capcomp_a}, 6'h15);
		drive_val = 6'h3f;
		timer0_mode_field = 4'h4;
		timer1_io_ctrl_b = 4'h4;
		tick();
		chk({timer1_capcomp_b, timer1_capcomp_a, timer0_capcomp_d, timer0_capcomp_c,
			timer0_capcomp_b, timer0_capcomp_a}, 6'h10);
	endtask : t_capture

	task clk_case(input int ch, input logic [2:0] v, input logic [2:0] exp);
		timer_prescale_select = '0;
		timer_prescale_select[3*ch+:3] = v;
		tick();
		chk({timer_ext_clock_c, timer_ext_clock_b, timer_ext_clock_a}, exp);
	endtask : clk_case

	task t_clocks;
		clear();
		drive_en = 6'h3f;
		drive_val = 6'h3f;
		clk_case(0, 3'h4, 3'h1);
		clk_case(5, 3'h4, 3'h1);
		clk_case(0, 3'h5, 3'h2);
		clk_case(2, 3'h5, 3'h2);
		clk_case(3, 3'h5, 3'h0);
		clk_case(0, 3'h7, 3'h4);
		clk_case(2, 3'h7, 3'h4);
		clk_case(1, 3'h7, 3'h0);
		clk_case(4, 3'h5, 3'h4);
		clk_case(5, 3'h5, 3'h4);
		timer_prescale_select = '0;
		phase_count_ch1_ch5 = 1'b1;
		tick();
		chk({timer_ext_clock_c, timer_ext_clock_b, timer_ext_clock_a}, 3'h3);
		phase_count_ch1_ch5 = 1'b0;
		phase_count_ch2_ch4 = 1'b1;
		tick();
		chk({timer_ext_clock_c, timer_ext_clock_b, timer_ext_clock_a}, 3'h4);
		drive_val = 6'h00;
		tick();
		chk(timer_ext_clock_c, 1'b0);
	endtask : t_clocks

	task dreq(input logic cm, input logic [5:0] pins, input logic [5:0] exp);
		dma_compat_mode = cm;
		drive_val = pins;
		tick();
		chk(dma_request, exp);
	endtask : dreq

	task dack(input logic cm, input logic [5:0] ack, input logic [1:0] exp);
		dma_compat_mode = cm;
		dma_acknowledge = ack;
		tick();
		chk({pin_oe[5:4], pin_out[5:4]}, {2'h3, exp});
		chk(pin_source[5:4], {P1FS_SRC_PERIPH, P1FS_SRC_PERIPH});
	endtask : dack

	task tend(input logic cm, input logic [2:0] hi, input logic [2:0] lo, input logic b1,
		input logic b0, input int i13, input int i12);
		dma_compat_mode = cm;
		dma_end_route_select_hi = hi;
		dma_end_route_select_lo = lo;
		ext_end_route_bit1 = b1;
		ext_end_route_bit0 = b0;
		transfer_end = (6'h01 << i13) | (6'h01 << i12);
		tick();
		chk({pin_oe[3:2], pin_out[3:2]}, 4'hf);
		transfer_end = ~transfer_end;
		tick();
		chk({pin_oe[3:2], pin_out[3:2]}, 4'hc);
	endtask : tend

	task t_dma;
		clear();
		drive_en = 6'h3f;
		dreq(1'b0, 6'h01, 6'h11);
		dreq(1'b1, 6'h01, 6'h12);
		dreq(1'b0, 6'h02, 6'h22);
		dreq(1'b1, 6'h02, 6'h28);
		clear();
		pin_direction = 6'h3f;
		{ext_single_addr_enable_0, ext_single_addr_enable_1} = 2'h3;
		{single_addr_enable_ch0, single_addr_enable_ch1} = 2'h3;
		dack(1'b0, 6'h0a, 2'h2);
		dack(1'b0, 6'h05, 2'h1);
		dack(1'b1, 6'h0a, 2'h3);
		dack(1'b1, 6'h05, 2'h0);
		clear();
		{transfer_end_enable_ch0, transfer_end_enable_ch1} = 2'h3;
		{ext_transfer_end_enable_0, ext_transfer_end_enable_1} = 2'h3;
		{ext_transfer_end_enable_4, ext_transfer_end_enable_5} = 2'h3;
		tend(1'b1, 3'h4, 3'h4, 1'b0, 1'b0, 5, 4);
		tend(1'b1, 3'h2, 3'h3, 1'b0, 1'b0, 3, 1);
		tend(1'b0, 3'h0, 3'h0, 1'b0, 1'b0, 1, 0);
		tend(1'b0, 3'h0, 3'h0, 1'b1, 1'b1, 5, 4);
		dma_compat_mode = 1'b1;
		tick();
		chk(pin_oe[3:2], 2'h0);
	endtask : t_dma

	task t_serial;
		clear();
		serial_pin_group_select = P1FS_SERIAL_GROUP_A;
		{serial_in_used, serial_out_used} = 2'h3;
		drive_en = 6'h3f;
		drive_val = 6'h20;
		tick();
		chk({sync_serial_in_a, sync_serial_out_a}, 2'h2);
		drive_val = 6'h10;
		tick();
		chk({sync_serial_in_a, sync_serial_out_a}, 2'h1);
		serial_pin_group_select = 2'h1;
		drive_val = 6'h30;
		tick();
		chk({sync_serial_in_a, sync_serial_out_a}, 2'h0);
		serial_pin_group_select = P1FS_SERIAL_GROUP_A;
		drive_en = 6'h00;
		{serial_out_drive, serial_out_data} = 2'h3;
		tick();
		chk({pin_oe[4], pin_out[4], pin_source[4]}, {2'h3, P1FS_SRC_PERIPH});
	endtask : t_serial

	initial begin
		reset_n = 1'b0;
		clear();
		repeat (3) @(posedge clock);
		#5;
		chk({pin_oe, pin_out, dma_request}, 18'h0);
		chk(pin_source, {6{P1FS_SRC_PORT}});
		reset_n = 1'b1;
		t_port();
		t_capture();
		t_clocks();
		t_dma();
		t_serial();
		summarize();
	end

	// the sequence takes under 100 cycles; allow twenty times that
	initial begin
		repeat (2000) @(posedge clock);
		mismatches++;
		summarize();
	end
endmodule : p1fs_port1_function_select_tb_top
